//--- src/pmc_pkg.sv
package pmc_pkg;
   // Register byte addresses
   localparam logic [31:0] PMC_ADDR_MODE = 32'h4000_5000;
   localparam logic [31:0] PMC_ADDR_KEY = 32'h4000_5004;
   localparam int PMC_DW = 16;
   localparam logic [15:0] PMC_RESET_VAL = 16'h0000;
   // Field positions in the mode register
   localparam int PMC_MODE_LSB = 0;
   localparam int PMC_DEEP_BIT = 3;
   // Unlock key values
   localparam logic [15:0] PMC_KEY_FIRST = 16'h4859;
   localparam logic [15:0] PMC_KEY_SECOND = 16'hF27B;
   // Interrupt sources and the set that wakes deep modes
   localparam int PMC_NIRQ = 74;
   localparam logic [PMC_NIRQ-1:0] PMC_WAKE_MASK = {{(PMC_NIRQ-10){1'b0}}, 10'h3FF};
   // Core system control values that request deep sleep
   localparam logic [2:0] PMC_SCR_DEEP_A = 3'h4;
   localparam logic [2:0] PMC_SCR_DEEP_B = 3'h6;

   // Mode field encodings
   typedef enum logic [1:0] {
      PMC_MODE_ACTIVE = 2'b00,
      PMC_MODE_CORE = 2'b01,
      PMC_MODE_SYS = 2'b10,
      PMC_MODE_HIB = 2'b11
   } pmc_mode_t;

   // Key protection progress
   typedef enum logic [1:0] {
      PMC_KEY_LOCKED = 2'b00,
      PMC_KEY_HALF = 2'b01,
      PMC_KEY_OPEN = 2'b10
   } pmc_key_t;
endpackage

//--- src/pmc_if.sv
`timescale 1ns/1ns
`default_nettype none
// Link between the power mode controller and the core with its interrupt controller
interface pmc_if;
   import pmc_pkg::*;
   logic reg_wr; // Register write strobe, one cycle
   logic reg_rd; // Register read strobe, one cycle
   logic [31:0] reg_addr; // Register byte address
   logic [15:0] reg_wdata; // Write data
   logic [15:0] reg_rdata; // Read data, registered
   logic reg_rvalid; // Read data valid pulse
   logic core_sleep; // Core has executed its wait instruction
   logic core_sleepdeep; // Core control register asks for deep sleep
   logic in_handler; // Core is inside an interrupt handler
   logic [PMC_NIRQ-1:0] irq_pend; // Pending interrupt sources
   logic [PMC_NIRQ-1:0] irq_higher; // Sources above the running handler
   logic wake; // Wake pulse back to the core

   modport dev (input reg_wr, reg_rd, reg_addr, reg_wdata, core_sleep, core_sleepdeep,
      in_handler, irq_pend, irq_higher, output reg_rdata, reg_rvalid, wake);
   modport core (output reg_wr, reg_rd, reg_addr, reg_wdata, core_sleep, core_sleepdeep,
      in_handler, irq_pend, irq_higher, input reg_rdata, reg_rvalid, wake);
endinterface
`default_nettype wire

//--- src/pmc_device.sv
`timescale 1ns/1ns
`default_nettype none
// Always-on power mode controller
module pmc_device
   import pmc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic por_n,
   pmc_if.dev lnk,
   input wire logic dbg_hold_set,
   output logic core_clk_en,
   output logic hclk_en,
   output logic peripheral_clock_a_en,
   output logic peripheral_clock_b_en,
   output logic nested_vector_irq_ctrl_clk_en,
   output logic comb_power_en,
   output logic retain,
   output logic periph_cfg_lock,
   output logic [1:0] mode_in_effect,
   output logic dbg_hold
);

   // Sleep states, also the mode in effect
   typedef enum logic [1:0] {
      PMC_ST_ACTIVE = 2'b00,
      PMC_ST_CORE = 2'b01,
      PMC_ST_SYS = 2'b10,
      PMC_ST_HIB = 2'b11
   } pmc_state_t;

   // Picks the sleep depth from stored mode, deep bit and core request
   function automatic pmc_state_t pick_depth(input logic [1:0] m, input logic deep, input logic sdeep);
      pmc_state_t d;
      d = PMC_ST_CORE;
      if (deep && m == PMC_MODE_SYS) begin
         d = PMC_ST_SYS;
      end else if (deep && m == PMC_MODE_HIB) begin
         // Full hibernate also needs the core's own deep request
         d = sdeep ? PMC_ST_HIB : PMC_ST_SYS;
      end
      return d;
   endfunction

   logic [1:0] mode_sel; // Last accepted mode field
   logic deep_sleep_enable; // Stored deep-sleep bit
   logic [15:0] power_unlock_key; // Last value written to the key register
   pmc_key_t key_st; // Key protection progress
   pmc_state_t st; // Current sleep state
   logic [15:0] rdata; // Registered read data
   logic rvalid; // Read data valid
   logic wake; // Registered wake pulse
   logic [1:0] next_mode_sel;
   logic next_deep_sleep_enable;
   logic [15:0] next_power_unlock_key;
   pmc_key_t next_key_st;
   pmc_state_t next_st;
   logic [15:0] next_rdata;
   logic next_rvalid;
   logic next_wake;
   logic next_dbg_hold;
   logic [PMC_NIRQ-1:0] eligible; // Sources allowed to wake at all
   logic wake_core; // Wake condition for core sleep
   logic wake_deep; // Wake condition for system sleep and hibernate

   // Register file and key protection
   always_comb begin
      next_mode_sel = mode_sel;
      next_deep_sleep_enable = deep_sleep_enable;
      next_power_unlock_key = power_unlock_key;
      next_key_st = key_st;
      next_rdata = rdata;
      next_rvalid = 1'b0;
      if (lnk.reg_wr) begin
         if (lnk.reg_addr == PMC_ADDR_KEY) begin
            next_power_unlock_key = lnk.reg_wdata;
            if (lnk.reg_wdata == PMC_KEY_FIRST) begin
               next_key_st = PMC_KEY_HALF;
            end else if (lnk.reg_wdata == PMC_KEY_SECOND && key_st == PMC_KEY_HALF) begin
               next_key_st = PMC_KEY_OPEN;
            end else begin
               // A wrong key value breaks the sequence
               next_key_st = PMC_KEY_LOCKED;
            end
         end else if (lnk.reg_addr == PMC_ADDR_MODE) begin
            // Locked writes are dropped; each change uses up the unlock
            if (key_st == PMC_KEY_OPEN) begin
               next_mode_sel = lnk.reg_wdata[PMC_MODE_LSB +: 2];
               next_deep_sleep_enable = lnk.reg_wdata[PMC_DEEP_BIT];
            end
            next_key_st = PMC_KEY_LOCKED;
         end else begin
            // Any other register write relocks
            next_key_st = PMC_KEY_LOCKED;
         end
      end
      if (lnk.reg_rd) begin
         next_rvalid = 1'b1;
         if (lnk.reg_addr == PMC_ADDR_MODE) begin
            // Shows the stored field, not the state in effect
            next_rdata = {12'h000, deep_sleep_enable, 1'b0, mode_sel};
         end else if (lnk.reg_addr == PMC_ADDR_KEY) begin
            next_rdata = power_unlock_key;
         end else begin
            next_rdata = 16'h0000;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         mode_sel <= PMC_RESET_VAL[1:0];
         deep_sleep_enable <= 1'b0;
         power_unlock_key <= PMC_RESET_VAL;
         key_st <= PMC_KEY_LOCKED;
         rdata <= 16'h0000;
         rvalid <= 1'b0;
      end else begin
         mode_sel <= next_mode_sel;
         deep_sleep_enable <= next_deep_sleep_enable;
         power_unlock_key <= next_power_unlock_key;
         key_st <= next_key_st;
         rdata <= next_rdata;
         rvalid <= next_rvalid;
      end
   end

   // Wake qualification; inside a handler only higher priority sources count
   always_comb begin
      eligible = lnk.in_handler ? (lnk.irq_pend & lnk.irq_higher) : lnk.irq_pend;
      wake_core = |eligible;
      wake_deep = |(eligible & PMC_WAKE_MASK);
   end

   // Sleep state machine
   always_comb begin
      next_st = st;
      next_wake = 1'b0;
      case (st)
         PMC_ST_ACTIVE: begin
            // Depth is fixed at the moment the core goes to sleep
            // The core still shows sleep while the wake pulse is out, so no re-entry then
            if (lnk.core_sleep && !wake) begin
               next_st = pick_depth(mode_sel, deep_sleep_enable, lnk.core_sleepdeep);
            end
         end
         PMC_ST_CORE: begin
            if (wake_core) begin
               next_st = PMC_ST_ACTIVE;
               next_wake = 1'b1;
            end
         end
         PMC_ST_SYS, PMC_ST_HIB: begin
            if (wake_deep) begin
               next_st = PMC_ST_ACTIVE;
               next_wake = 1'b1;
            end
         end
         default: begin
            next_st = PMC_ST_ACTIVE;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st <= PMC_ST_ACTIVE;
         wake <= 1'b0;
      end else begin
         st <= next_st;
         wake <= next_wake;
      end
   end

   // Debug hold survives every reset except power-on
   always_comb begin
      next_dbg_hold = dbg_hold | dbg_hold_set;
   end

   always_ff @(posedge mclk) begin
      if (!por_n) begin
         dbg_hold <= 1'b0;
      end else begin
         dbg_hold <= next_dbg_hold;
      end
   end

   // Gate outputs registered from the next state; debug hold keeps all clocks up
   logic next_core_clk_en;
   logic next_hclk_en;
   logic next_nested_vector_irq_ctrl_clk_en;
   logic next_comb_power_en;
   logic next_retain;
   logic next_periph_cfg_lock;
   always_comb begin
      // Core clock stops only once sleep is entered
      next_core_clk_en = (next_st == PMC_ST_ACTIVE) || next_dbg_hold;
      // Bus stays up in core sleep so DMA keeps moving
      next_hclk_en = (next_st == PMC_ST_ACTIVE) || (next_st == PMC_ST_CORE) || next_dbg_hold;
      next_nested_vector_irq_ctrl_clk_en = (next_st != PMC_ST_HIB) || next_dbg_hold;
      next_comb_power_en = (next_st != PMC_ST_HIB) || next_dbg_hold;
      next_retain = (next_st == PMC_ST_HIB) && !next_dbg_hold;
      next_periph_cfg_lock = (next_st == PMC_ST_SYS) || (next_st == PMC_ST_HIB);
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         core_clk_en <= 1'b1;
         hclk_en <= 1'b1;
         nested_vector_irq_ctrl_clk_en <= 1'b1;
         comb_power_en <= 1'b1;
         retain <= 1'b0;
         periph_cfg_lock <= 1'b0;
      end else begin
         core_clk_en <= next_core_clk_en;
         hclk_en <= next_hclk_en;
         nested_vector_irq_ctrl_clk_en <= next_nested_vector_irq_ctrl_clk_en;
         comb_power_en <= next_comb_power_en;
         retain <= next_retain;
         periph_cfg_lock <= next_periph_cfg_lock;
      end
   end

   // Peripheral bus clocks follow the system bus clock
   assign peripheral_clock_a_en = hclk_en;
   assign peripheral_clock_b_en = hclk_en;
   assign mode_in_effect = st;
   assign lnk.reg_rdata = rdata;
   assign lnk.reg_rvalid = rvalid;
   assign lnk.wake = wake;

endmodule
`default_nettype wire

//--- src/pmc_core_end.sv
`timescale 1ns/1ns
`default_nettype none
// Core side: register requests, sleep signalling and interrupt state
module pmc_core_end
   import pmc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   pmc_if.core lnk,
   input wire logic sw_wr,
   input wire logic sw_rd,
   input wire logic [31:0] sw_addr,
   input wire logic [15:0] sw_wdata,
   output logic sw_ready,
   output logic [15:0] sw_rdata,
   output logic sw_rvalid,
   input wire logic scr_wr,
   input wire logic [2:0] scr_wdata,
   input wire logic wait_for_irq_instruction,
   input wire logic handler_active,
   input wire logic [PMC_NIRQ-1:0] irq_req,
   input wire logic [PMC_NIRQ-1:0] irq_above,
   output logic sleeping
);

   logic [2:0] scr; // Core system control value
   logic [15:0] rdata_q; // Captured read data
   logic rvalid_q; // Read capture valid
   logic [2:0] next_scr;
   logic next_sleeping;
   logic [15:0] next_rdata_q;
   logic next_rvalid_q;

   // Sleep entry on the wait instruction, exit on the wake pulse
   always_comb begin
      next_scr = scr_wr ? scr_wdata : scr;
      next_sleeping = sleeping;
      // Wake wins so a stray wait in the same cycle does not re-sleep
      if (lnk.wake) begin
         next_sleeping = 1'b0;
      end else if (wait_for_irq_instruction && !sleeping) begin
         next_sleeping = 1'b1;
      end
      next_rdata_q = lnk.reg_rvalid ? lnk.reg_rdata : rdata_q;
      next_rvalid_q = lnk.reg_rvalid;
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         scr <= 3'h0;
         sleeping <= 1'b0;
         rdata_q <= 16'h0000;
         rvalid_q <= 1'b0;
      end else begin
         scr <= next_scr;
         sleeping <= next_sleeping;
         rdata_q <= next_rdata_q;
         rvalid_q <= next_rvalid_q;
      end
   end

   // A sleeping core issues no register traffic
   assign sw_ready = !sleeping;
   assign lnk.reg_wr = sw_wr && !sleeping;
   assign lnk.reg_rd = sw_rd && !sleeping;
   assign lnk.reg_addr = sw_addr;
   assign lnk.reg_wdata = sw_wdata;
   assign lnk.core_sleep = sleeping;
   // Deep request only for the two documented control values
   assign lnk.core_sleepdeep = (scr == PMC_SCR_DEEP_A) || (scr == PMC_SCR_DEEP_B);
   assign lnk.in_handler = handler_active;
   assign lnk.irq_pend = irq_req;
   assign lnk.irq_higher = irq_above;
   assign sw_rdata = rdata_q;
   assign sw_rvalid = rvalid_q;

endmodule
`default_nettype wire

//--- sim/pmc_asserts.sv
`timescale 1ns/1ns
`default_nettype none
// Watches the link between the core end and the device
module pmc_asserts
   import pmc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic core_sleep,
   input wire logic core_sleepdeep,
   input wire logic in_handler,
   input wire logic [PMC_NIRQ-1:0] irq_pend,
   input wire logic [PMC_NIRQ-1:0] irq_higher,
   input wire logic wake
);
   // One clock domain, so one default clocking and one reset guard
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // Every read is answered exactly one cycle later
   property p_rd_ans; reg_rd |=> reg_rvalid; endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
   // No answer without a read before it
   property p_rv_cause; reg_rvalid |-> $past(reg_rd); endproperty
   a_rv_cause: assert property (p_rv_cause) else $error("stray read answer");
   // Mode readback keeps bit 2 and the upper bits clear
   property p_mode_rd; reg_rd && reg_addr == PMC_ADDR_MODE |=> reg_rdata[15:4] == 12'h000 && !reg_rdata[2]; endproperty
   a_mode_rd: assert property (p_mode_rd) else $error("mode readback reserved bits set");
   // Unmapped reads return zero
   property p_unmapped;
      reg_rd && reg_addr != PMC_ADDR_MODE && reg_addr != PMC_ADDR_KEY |=> reg_rdata == 16'h0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   // Wake is a single cycle pulse
   property p_wake_pulse; wake |=> !wake; endproperty
   a_wake_pulse: assert property (p_wake_pulse) else $error("wake longer than one cycle");
   // Wake comes only while asleep, and the core is awake one cycle on
   property p_wake_asleep; wake |-> core_sleep ##1 !core_sleep; endproperty
   a_wake_asleep: assert property (p_wake_asleep) else $error("wake not tied to sleep");
   // Wake needs a pending source the cycle before
   property p_wake_cause; wake |-> $past(|irq_pend); endproperty
   a_wake_cause: assert property (p_wake_cause) else $error("wake without pending source");
   // Inside a handler only a higher source may wake
   property p_wake_handler; wake |-> $past(!in_handler || |(irq_pend & irq_higher)); endproperty
   a_wake_handler: assert property (p_wake_handler) else $error("handler wake by lower source");
   // A sleeping core issues no register traffic
   property p_quiet; core_sleep |-> !reg_wr && !reg_rd; endproperty
   a_quiet: assert property (p_quiet) else $error("register access while asleep");
   // Main scenarios reached
   c_read: cover property (reg_rvalid);
   c_wake: cover property (wake);
   c_deep: cover property (core_sleep && core_sleepdeep);
   c_handler: cover property (wake && in_handler);
endmodule
`default_nettype wire

//--- sim/power_mode_controller_test.sv
`timescale 1ns/1ns
`default_nettype none
// Drives both ends of the power mode link and scores the results
module power_mode_controller_test;
   import pmc_pkg::*;
   logic mclk, rst_n, por_n, dbg_hold_set, sw_wr, sw_rd, scr_wr, wait_for_irq_instruction, handler_active;
   logic [31:0] sw_addr;
   logic [15:0] sw_wdata, sw_rdata, d, cur;
   logic [2:0] scr_wdata;
   logic [PMC_NIRQ-1:0] irq_req, irq_above;
   logic sw_ready, sw_rvalid, sleeping, core_clk_en, hclk_en, pca, pcb, nested_vector_irq_ctrl_clk_en;
   logic comb_power_en, retain, periph_cfg_lock, dbg_hold;
   logic [1:0] mode_in_effect;
   logic [9:0] gv; // All gating outputs in one vector
   logic [15:0] exp_q[$]; // Read results still owed by the design
   int miscompares, cmp_count, cycles, seed, i, m, dp, sd, idx;
   pmc_if lnk();
   pmc_device pmc_device_i(.mclk(mclk), .rst_n(rst_n), .por_n(por_n), .lnk(lnk), .dbg_hold_set(dbg_hold_set),
      .core_clk_en(core_clk_en), .hclk_en(hclk_en), .peripheral_clock_a_en(pca), .peripheral_clock_b_en(pcb),
      .nested_vector_irq_ctrl_clk_en(nested_vector_irq_ctrl_clk_en), .comb_power_en(comb_power_en), .retain(retain),
      .periph_cfg_lock(periph_cfg_lock), .mode_in_effect(mode_in_effect), .dbg_hold(dbg_hold));
   pmc_core_end pmc_core_end_i(.mclk(mclk), .rst_n(rst_n), .lnk(lnk), .sw_wr(sw_wr), .sw_rd(sw_rd),
      .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_ready(sw_ready), .sw_rdata(sw_rdata), .sw_rvalid(sw_rvalid),
      .scr_wr(scr_wr), .scr_wdata(scr_wdata), .wait_for_irq_instruction(wait_for_irq_instruction), .handler_active(handler_active), .irq_req(irq_req),
      .irq_above(irq_above), .sleeping(sleeping));
   pmc_asserts chk_i(.mclk(mclk), .rst_n(rst_n), .reg_wr(lnk.reg_wr), .reg_rd(lnk.reg_rd),
      .reg_addr(lnk.reg_addr), .reg_wdata(lnk.reg_wdata), .reg_rdata(lnk.reg_rdata), .reg_rvalid(lnk.reg_rvalid),
      .core_sleep(lnk.core_sleep), .core_sleepdeep(lnk.core_sleepdeep), .in_handler(lnk.in_handler),
      .irq_pend(lnk.irq_pend), .irq_higher(lnk.irq_higher), .wake(lnk.wake));
   assign gv = {core_clk_en, hclk_en, pca, pcb, nested_vector_irq_ctrl_clk_en, comb_power_en, retain, periph_cfg_lock, mode_in_effect};
   // 10 MHz clock
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   // Expected gating per state: active, core, system, hibernate
   function automatic logic [9:0] gate(input logic [1:0] st);
      case (st)
         2'b00: gate = 10'b1111110000;
         2'b01: gate = 10'b0111110001;
         2'b10: gate = 10'b0000110110;
         default: gate = 10'b0000001111;
      endcase
   endfunction
   // Inputs move 1 ns after the edge so no race with the design
   task automatic tick;
      @(posedge mclk);
      #1;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("FAIL t=%0t got %h exp %h", $time, seen, exp);
      end
   endtask
   // Strobes stay up between calls so back to back needs no gap
   task automatic wr(input logic [31:0] a, input logic [15:0] v);
      sw_wr = 1'b1;
      sw_rd = 1'b0;
      sw_addr = a;
      sw_wdata = v;
      tick;
   endtask
   task automatic rd(input logic [31:0] a, input logic [15:0] e);
      sw_wr = 1'b0;
      sw_rd = 1'b1;
      sw_addr = a;
      exp_q.push_back(e);
      tick;
   endtask
   // Drops all strobes and lets an edge pass
   task automatic rel;
      sw_wr = 1'b0;
      sw_rd = 1'b0;
      scr_wr = 1'b0;
      tick;
   endtask
   task automatic set_mode(input logic [15:0] v, input logic [2:0] s);
      wr(PMC_ADDR_KEY, PMC_KEY_FIRST);
      wr(PMC_ADDR_KEY, PMC_KEY_SECOND);
      scr_wr = 1'b1;
      scr_wdata = s;
      wr(PMC_ADDR_MODE, v);
      rel;
   endtask
   task automatic nap(input logic [1:0] st);
      wait_for_irq_instruction = 1'b1;
      tick;
      wait_for_irq_instruction = 1'b0;
      repeat (4) tick;
      check({6'h00, gv}, {6'h00, gate(st)});
      check({15'h0000, sw_ready}, 16'h0000);
   endtask
   // Raises one source and waits a bounded time for the wake
   task automatic rouse(input int b);
      irq_req[b] = 1'b1;
      for (int k = 0; k < 20 && sleeping !== 1'b0; k++)
         tick;
      irq_req = '0;
      check({15'h0000, sleeping}, 16'h0000);
      check({6'h00, gv}, {6'h00, gate(2'b00)});
   endtask
   task automatic test_done;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Read results are scored in order, mid-cycle so the flops have settled
   always @(negedge mclk) begin
      if (sw_rvalid === 1'b1) begin
         if (exp_q.size() == 0) begin
            miscompares++;
            $display("FAIL t=%0t unexpected read data", $time);
         end else
            check(sw_rdata, exp_q.pop_front());
      end
   end
   // Hang guard, far above the few hundred cycles the run needs
   always @(posedge mclk) begin
      cycles++;
      if (cycles > 4000) begin
         miscompares++;
         $display("FAIL t=%0t timeout", $time);
         test_done;
      end
   end
   initial begin
      seed = 70051;
      {rst_n, por_n, dbg_hold_set, sw_wr, sw_rd, scr_wr, wait_for_irq_instruction, handler_active} = 8'h00;
      sw_addr = '0;
      sw_wdata = '0;
      scr_wdata = '0;
      irq_req = '0;
      irq_above = '0;
      repeat (10) tick;
      rst_n = 1'b1;
      por_n = 1'b1;
      check({6'h00, gv}, {6'h00, gate(2'b00)});
      rd(PMC_ADDR_MODE, PMC_RESET_VAL);
      rd(PMC_ADDR_KEY, PMC_RESET_VAL);
      rd(32'h4000_5008, 16'h0000);
      rel;
      $display("reset test done");
      // Random data in every mode, reserved bits masked on readback
      for (i = 0; i < 4; i++) begin
         d = 16'($random(seed));
         d[1:0] = i[1:0];
         set_mode(d, 3'h0);
         rd(PMC_ADDR_MODE, {12'h000, d[3], 1'b0, d[1:0]});
      end
      cur = {12'h000, d[3], 1'b0, d[1:0]};
      wr(PMC_ADDR_MODE, 16'h0009);
      wr(PMC_ADDR_KEY, PMC_KEY_FIRST);
      wr(32'h4000_5008, 16'h0000);
      wr(PMC_ADDR_KEY, PMC_KEY_SECOND);
      wr(PMC_ADDR_MODE, 16'h0009);
      wr(PMC_ADDR_KEY, PMC_KEY_FIRST);
      wr(PMC_ADDR_KEY, PMC_KEY_SECOND);
      wr(PMC_ADDR_KEY, 16'h1234);
      wr(PMC_ADDR_MODE, 16'h0009);
      rd(PMC_ADDR_MODE, cur);
      rel;
      $display("key test done");
      // Every mode, deep bit and core deep request
      for (m = 0; m < 4; m++)
         for (dp = 0; dp < 2; dp++)
            for (sd = 0; sd < 2; sd++) begin
               d = {12'h000, dp[0], 1'b0, m[1:0]};
               set_mode(d, sd == 1 ? (m[0] ? 3'h6 : 3'h4) : 3'h0);
               nap(dp == 0 || m < 2 ? 2'b01 : (m == 3 && sd == 1 ? 2'b11 : 2'b10));
               rouse(0);
               rd(PMC_ADDR_MODE, d);
               rel;
            end
      $display("sleep test done");
      // A source outside the wake set leaves deep sleep alone
      idx = 10 + ({$random(seed)} % 64);
      set_mode(16'h000A, 3'h0);
      nap(2'b10);
      irq_req[idx] = 1'b1;
      repeat (5) tick;
      check({15'h0000, sleeping}, 16'h0001);
      rouse(0);
      set_mode(16'h0001, 3'h0);
      nap(2'b01);
      rouse(idx);
      $display("wake source test done");
      // Inside a handler a lower source must not wake
      handler_active = 1'b1;
      nap(2'b01);
      irq_req[5] = 1'b1;
      repeat (5) tick;
      check({15'h0000, sleeping}, 16'h0001);
      irq_above[5] = 1'b1;
      rouse(5);
      handler_active = 1'b0;
      irq_above = '0;
      $display("handler test done");
      // Debug hold blocks gating and survives all but power-on reset
      dbg_hold_set = 1'b1;
      tick;
      dbg_hold_set = 1'b0;
      set_mode(16'h000B, 3'h4);
      wait_for_irq_instruction = 1'b1;
      tick;
      wait_for_irq_instruction = 1'b0;
      repeat (4) tick;
      check({12'h000, core_clk_en, hclk_en, comb_power_en, retain}, 16'h000E);
      rouse(0);
      rst_n = 1'b0;
      tick;
      rst_n = 1'b1;
      check({15'h0000, dbg_hold}, 16'h0001);
      check({6'h00, gv}, {6'h00, gate(2'b00)});
      por_n = 1'b0;
      tick;
      por_n = 1'b1;
      tick;
      check({15'h0000, dbg_hold}, 16'h0000);
      $display("debug test done");
      repeat (3) tick;
      check(16'(exp_q.size()), 16'h0000);
      test_done;
   end
endmodule
`default_nettype wire
